/* File: verilog/csim_regs.sv */
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// - Any status access clears status register
// - DAC2 buffer empty sets DAC2 underrun
// - DAC1 buffer empty sets DAC1 underrun
// - Underrunning DAC gets zero samples
// - Underrun sticks until status access or disable
// - Right ADC peak level kept, four codes
// - Left ADC peak level kept, same codes
// - Peak only rises; status access clears to 00
// - ADC channel disable clears its peak
// - Status zero in reset or power-down
// - Left ADC source select, eight inputs
// - Right ADC source select, eight inputs
// - Mic boost bit per channel, +20 dB
// - Four-bit ADC gain, 1.5 dB steps
// - ADC register zero, write-locked in power-down
// - Five-bit DAC2 mix gain per side
// - Mix register 8888, locked in power-down
// - Mix register locked by mix enables
// - Power-down flag set during transitions too
module csim_regs (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic powerdown_pin_n,
    input wire csim_pkg::csim_stereo_t [1:0] dac_in_data,
    input wire logic [1:0] dac_in_valid,
    output logic [1:0] dac_in_ready,
    input wire logic [1:0] dac_tick,
    output csim_pkg::csim_stereo_t [1:0] dac_out,
    input wire logic [1:0] adc_left_level,
    input wire logic [1:0] adc_right_level,
    input wire logic adc_level_valid,
    output logic [2:0] left_adc_source,
    output logic [2:0] right_adc_source,
    output logic left_mic_boost,
    output logic right_mic_boost,
    output logic [3:0] left_adc_gain,
    output logic [3:0] right_adc_gain,
    output logic left_dac2_mix_mute,
    output logic right_dac2_mix_mute,
    output logic [4:0] left_dac2_mix_gain,
    output logic [4:0] right_dac2_mix_gain,
    output logic [5:0] channel_enables,
    output logic converter_powerdown_flag
);

    // Bus front end

    logic req_take;
    csim_pkg::csim_ahb_req_t req_d;
    csim_pkg::csim_ahb_req_t req_q;
    logic wr_now;
    logic rd_take;
    logic rd_wait;

    // A read taken during a write's data phase would capture the old word,
    // so that read is held for one cycle until the write has landed
    assign rd_wait = wr_now & hsel & htrans[1] & ~hwrite;
    assign hreadyout = ~rd_wait;
    assign hresp = 1'b0;
    assign req_take = hsel & htrans[1] & hready;
    assign req_d.widx = haddr[11:2];
    assign req_d.write = hwrite;
    assign req_d.valid = req_take;
    assign wr_now = req_q.valid & req_q.write;
    assign rd_take = req_take & ~hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
        hit = (a == b);
    endfunction

    logic wr_status;
    logic wr_adc;
    logic wr_mix;
    logic wr_en;
    logic wr_ctl;
    logic rd_status;
    logic stat_clr;

    always_comb begin
        wr_status = 1'b0;
        wr_adc = 1'b0;
        wr_mix = 1'b0;
        wr_en = 1'b0;
        wr_ctl = 1'b0;
        if (wr_now) begin
            if (hit(req_q.widx, csim_pkg::IDX_STATUS)) begin
                wr_status = 1'b1;
            end else if (hit(req_q.widx, csim_pkg::IDX_ADC)) begin
                wr_adc = 1'b1;
            end else if (hit(req_q.widx, csim_pkg::IDX_MIX)) begin
                wr_mix = 1'b1;
            end else if (hit(req_q.widx, csim_pkg::IDX_PWR_EN)) begin
                wr_en = 1'b1;
            end else if (hit(req_q.widx, csim_pkg::IDX_PWR_CTL)) begin
                wr_ctl = 1'b1;
            end
        end
    end
    assign rd_status = rd_take & hit(haddr[11:2], csim_pkg::IDX_STATUS);
    // Read clears once the old value is captured for the data phase
    assign stat_clr = wr_status | rd_status;

    // Power-down pin synchroniser and converter power-down flag

    logic pd_meta_q;
    logic pd_pin_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_meta_q <= 1'b0;
            pd_pin_q <= 1'b0;
        end else begin
            pd_meta_q <= powerdown_pin_n;
            pd_pin_q <= pd_meta_q;
        end
    end

    logic [15:0] en_q;
    logic [15:0] en_d;
    logic [15:0] ctl_q;
    logic [15:0] ctl_d;

    assign en_d = wr_en ? (hwdata[15:0] & csim_pkg::PWR_EN_MASK) : en_q;
    assign ctl_d = wr_ctl ? {15'h0000, hwdata[csim_pkg::PC_REQ]} : ctl_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= csim_pkg::PWR_EN_RESET;
            ctl_q <= csim_pkg::PWR_CTL_RESET;
        end else begin
            en_q <= en_d;
            ctl_q <= ctl_d;
        end
    end

    localparam logic [7:0] SETTLE = 8'(csim_pkg::PD_SETTLE_CYC);

    logic pd_req;
    logic pd_req_q;
    logic [7:0] settle_q;
    logic [7:0] settle_d;
    logic conv_pd;

    assign pd_req = ~pd_pin_q | ctl_q[csim_pkg::PC_REQ];
    // Any change of the request restarts the settle window
    assign settle_d = (pd_req != pd_req_q) ? SETTLE :
                      (settle_q != 8'h00) ? settle_q - 8'h01 : 8'h00;
    assign conv_pd = pd_req | pd_req_q | (settle_q != 8'h00);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_req_q <= 1'b1;
            settle_q <= SETTLE;
        end else begin
            pd_req_q <= pd_req;
            settle_q <= settle_d;
        end
    end

    assign converter_powerdown_flag = conv_pd;
    assign channel_enables = en_q[5:0];

    // ADC input select and gain register

    logic [15:0] adc_q;
    logic [15:0] adc_d;

    // Locked at zero while conversions are down; writes are dropped
    assign adc_d = conv_pd ? csim_pkg::ADC_RESET :
                   wr_adc ? hwdata[15:0] : adc_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_q <= csim_pkg::ADC_RESET;
        end else begin
            adc_q <= adc_d;
        end
    end

    assign left_adc_source = adc_q[15:13];
    assign right_adc_source = adc_q[7:5];
    assign left_mic_boost = adc_q[12];
    assign right_mic_boost = adc_q[4];
    assign left_adc_gain = adc_q[11:8];
    assign right_adc_gain = adc_q[3:0];

    // DAC2 to mixer register

    logic [15:0] mix_q;
    logic [15:0] mix_d;
    logic mix_hold;

    assign mix_hold = conv_pd | ~en_q[csim_pkg::EN_D2MIX]
                      | ~en_q[csim_pkg::EN_DAC2] | ~en_q[csim_pkg::EN_ANA];
    // Reserved bits never store, so they always read back as zero
    assign mix_d = mix_hold ? csim_pkg::MIX_RESET :
                   wr_mix ? (hwdata[15:0] & csim_pkg::MIX_MASK) :
                   mix_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mix_q <= csim_pkg::MIX_RESET;
        end else begin
            mix_q <= mix_d;
        end
    end

    assign left_dac2_mix_mute = mix_q[15];
    assign right_dac2_mix_mute = mix_q[7];
    assign left_dac2_mix_gain = mix_q[12:8];
    assign right_dac2_mix_gain = mix_q[4:0];

    // DAC input buffers, four stereo words per pair

    logic [1:0] under_q;
    logic [1:0] under_d;
    logic [1:0] dac_off;

    assign dac_off[0] = conv_pd | ~en_q[csim_pkg::EN_DAC1];
    assign dac_off[1] = conv_pd | ~en_q[csim_pkg::EN_DAC2];

    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_pair
            csim_pkg::csim_stereo_t mem_q [csim_pkg::FIFO_DEPTH];
            logic [1:0] wp_q;
            logic [1:0] rp_q;
            logic [2:0] cnt_q;
            logic [2:0] cnt_d;
            logic push;
            logic pop;
            logic empty;
            logic starve;

            assign empty = (cnt_q == 3'd0);
            assign dac_in_ready[p] = ~dac_off[p] & (cnt_q != 3'd4);
            assign push = dac_in_valid[p] & dac_in_ready[p];
            assign pop = dac_tick[p] & ~empty & ~dac_off[p];
            assign starve = dac_tick[p] & empty & ~dac_off[p];
            assign cnt_d = dac_off[p] ? 3'd0 :
                           3'(cnt_q + {2'b00, push} - {2'b00, pop});
            // Powered-down pair loses the flag; fresh starve beats clear
            assign under_d[p] = dac_off[p] ? 1'b0 :
                                starve ? 1'b1 :
                                stat_clr ? 1'b0 : under_q[p];

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wp_q <= 2'd0;
                    rp_q <= 2'd0;
                    cnt_q <= 3'd0;
                end else begin
                    wp_q <= dac_off[p] ? 2'd0 : wp_q + {1'b0, push};
                    rp_q <= dac_off[p] ? 2'd0 : rp_q + {1'b0, pop};
                    cnt_q <= cnt_d;
                end
            end

            always_ff @(posedge hclk) begin
                if (push) begin
                    mem_q[wp_q] <= dac_in_data[p];
                end
            end

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    dac_out[p] <= '0;
                end else if (dac_tick[p] | dac_off[p]) begin
                    // Missing sample plays as silence rather than repeating
                    dac_out[p] <= pop ? mem_q[rp_q] : '0;
                end
            end
        end
    endgenerate

    // ADC peak hold

    function automatic logic [1:0] peak_next(input logic [1:0] old,
                                             input logic clr,
                                             input logic vld,
                                             input logic [1:0] lvl);
        logic [1:0] base;
        base = clr ? 2'b00 : old;
        peak_next = (vld && lvl > base) ? lvl : base;
    endfunction

    logic [1:0] pk_l_q;
    logic [1:0] pk_r_q;
    logic [1:0] pk_l_d;
    logic [1:0] pk_r_d;
    logic adcl_off;
    logic adcr_off;

    assign adcl_off = conv_pd | ~en_q[csim_pkg::EN_ADCL];
    assign adcr_off = conv_pd | ~en_q[csim_pkg::EN_ADCR];
    assign pk_l_d = adcl_off ? 2'b00 :
                    peak_next(pk_l_q, stat_clr, adc_level_valid,
                              adc_left_level);
    assign pk_r_d = adcr_off ? 2'b00 :
                    peak_next(pk_r_q, stat_clr, adc_level_valid,
                              adc_right_level);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            under_q <= 2'b00;
            pk_l_q <= 2'b00;
            pk_r_q <= 2'b00;
        end else begin
            under_q <= under_d;
            pk_l_q <= pk_l_d;
            pk_r_q <= pk_r_d;
        end
    end

    // Read data, captured in the address phase

    logic [15:0] status_word;
    logic [15:0] rd_word;
    logic [9:0] ra;

    always_comb begin
        status_word = csim_pkg::STATUS_RESET;
        status_word[csim_pkg::ST_SU2] = under_q[1];
        status_word[csim_pkg::ST_SU1] = under_q[0];
        status_word[csim_pkg::ST_OVR +: 2] = pk_r_q;
        status_word[csim_pkg::ST_OVL +: 2] = pk_l_q;
    end

    assign ra = haddr[11:2];
    always_comb begin
        if (hit(ra, csim_pkg::IDX_STATUS)) begin
            rd_word = status_word;
        end else if (hit(ra, csim_pkg::IDX_ADC)) begin
            rd_word = adc_q;
        end else if (hit(ra, csim_pkg::IDX_MIX)) begin
            rd_word = mix_q;
        end else if (hit(ra, csim_pkg::IDX_PWR_EN)) begin
            rd_word = en_q;
        end else if (hit(ra, csim_pkg::IDX_PWR_CTL)) begin
            rd_word = ctl_q | {conv_pd, 15'h0000};
        end else begin
            rd_word = 16'h0000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata <= {16'h0000, rd_word};
        end
    end

endmodule

/* File: include/csim_pkg.sv */
package csim_pkg;

    // Word index of each register; byte address is four times the index
    localparam logic [9:0] IDX_STATUS = 10'h001;
    localparam logic [9:0] IDX_ADC = 10'h002;
    localparam logic [9:0] IDX_MIX = 10'h003;
    localparam logic [9:0] IDX_PWR_EN = 10'h01b;
    localparam logic [9:0] IDX_PWR_CTL = 10'h01c;

    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] ADC_RESET = 16'h0000;
    localparam logic [15:0] MIX_RESET = 16'h8888;
    localparam logic [15:0] MIX_MASK = 16'h9f9f;
    localparam logic [15:0] PWR_EN_RESET = 16'h0000;
    localparam logic [15:0] PWR_CTL_RESET = 16'h0001;

    // Status fields
    localparam int ST_SU2 = 9;
    localparam int ST_SU1 = 8;
    localparam int ST_OVR = 2;
    localparam int ST_OVL = 0;

    // Enable register fields
    localparam int EN_DAC1 = 0;
    localparam int EN_DAC2 = 1;
    localparam int EN_ADCL = 2;
    localparam int EN_ADCR = 3;
    localparam int EN_D2MIX = 4;
    localparam int EN_ANA = 5;
    localparam logic [15:0] PWR_EN_MASK = 16'h003f;

    // Power control fields
    localparam int PC_REQ = 0;
    localparam int PC_FLAG = 15;

    localparam int FIFO_DEPTH = 4;

    // Settling time around every power-down transition
    localparam int PD_SETTLE_NS = 320;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PD_SETTLE_CYC = (PD_SETTLE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;

    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
    } csim_stereo_t;

    typedef struct packed {
        logic [9:0] widx;
        logic write;
        logic valid;
    } csim_ahb_req_t;

endpackage

/* File: sim/csim_regs_monitor.sv */
`timescale 1ns/1ps
module csim_regs_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire csim_pkg::csim_stereo_t [1:0] dac_out,
    input wire logic [1:0] dac_in_ready,
    input wire logic [2:0] left_adc_source,
    input wire logic [2:0] right_adc_source,
    input wire logic left_mic_boost,
    input wire logic right_mic_boost,
    input wire logic [3:0] left_adc_gain,
    input wire logic [3:0] right_adc_gain,
    input wire logic left_dac2_mix_mute,
    input wire logic right_dac2_mix_mute,
    input wire logic [4:0] left_dac2_mix_gain,
    input wire logic [4:0] right_dac2_mix_gain,
    input wire logic [5:0] channel_enables,
    input wire logic converter_powerdown_flag
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire pd = converter_powerdown_flag;
    wire take = hsel && htrans[1] && hready;
    wire [9:0] widx = haddr[11:2];
    wire [15:0] adc_q = {left_adc_source, left_mic_boost, left_adc_gain,
                         right_adc_source, right_mic_boost, right_adc_gain};
    wire [15:0] mix_q = {left_dac2_mix_mute, 2'b00, left_dac2_mix_gain,
                         right_dac2_mix_mute, 2'b00, right_dac2_mix_gain};
    // Bits 4, 1 and 5 of the enable register gate the mix register
    wire mix_ok = !pd && channel_enables[4] && channel_enables[1]
                  && channel_enables[5];
    wire wr_adc = take && hwrite && widx == csim_pkg::IDX_ADC;
    wire wr_mix = take && hwrite && widx == csim_pkg::IDX_MIX;
    wire rd_st = take && !hwrite && widx == csim_pkg::IDX_STATUS;

    // Two samples so the clearing edge has landed
    a_adc_held: assert property (pd[*2] |-> adc_q == 16'h0000)
        else $error("ADC register not held in power-down");
    a_mix_held: assert property ((!mix_ok)[*2] |-> mix_q == 16'h8888)
        else $error("mix register not held at default");
    a_adc_write: assert property (
        wr_adc && !pd ##1 !pd |=> adc_q == $past(hwdata[15:0]))
        else $error("ADC fields differ from written word");
    a_mix_write: assert property (
        wr_mix && mix_ok ##1 mix_ok |=>
        mix_q == ($past(hwdata[15:0]) & csim_pkg::MIX_MASK))
        else $error("mix fields differ from written word");
    a_status_pd: assert property (pd ##1 rd_st |=> hrdata == 32'h0)
        else $error("status not zero in power-down");
    a_upper_zero: assert property (
        take && !hwrite |=> hrdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_flag_reset: assert property ($rose(hresetn) |-> pd)
        else $error("power-down flag low after reset");
    a_dac1_off: assert property (
        (!channel_enables[0] || pd)[*2] |->
        dac_out[0] == 32'h0 && !dac_in_ready[0])
        else $error("DAC1 pair active while off");
    a_dac2_off: assert property (
        (!channel_enables[1] || pd)[*2] |->
        dac_out[1] == 32'h0 && !dac_in_ready[1])
        else $error("DAC2 pair active while off");
endmodule

bind csim_regs csim_regs_monitor u_csim_regs_monitor (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .dac_out(dac_out), .dac_in_ready(dac_in_ready),
    .left_adc_source(left_adc_source), .right_adc_source(right_adc_source),
    .left_mic_boost(left_mic_boost), .right_mic_boost(right_mic_boost),
    .left_adc_gain(left_adc_gain), .right_adc_gain(right_adc_gain),
    .left_dac2_mix_mute(left_dac2_mix_mute),
    .right_dac2_mix_mute(right_dac2_mix_mute),
    .left_dac2_mix_gain(left_dac2_mix_gain),
    .right_dac2_mix_gain(right_dac2_mix_gain),
    .channel_enables(channel_enables),
    .converter_powerdown_flag(converter_powerdown_flag)
);

/* File: sim/csim_host.sv */
`timescale 1ns/1ps
module csim_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [11:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic stall
);
    initial begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        stall = 1'b0;
    end
    // Bound only guards against a hang; a slave may insert waits
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        if (n == 50)
            stall <= 1'b1;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [15:0] d, output logic [15:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        wait_rdy();
        q = hrdata[15:0];
    endtask
endmodule

/* File: sim/csim_regs_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    checks++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("BAD %s exp %h got %h", n, e, g); \
    end \
end
module csim_regs_test;
    localparam logic [11:0] A_ST = {csim_pkg::IDX_STATUS, 2'b00};
    localparam logic [11:0] A_ADC = {csim_pkg::IDX_ADC, 2'b00};
    localparam logic [11:0] A_MIX = {csim_pkg::IDX_MIX, 2'b00};
    localparam logic [11:0] A_EN = {csim_pkg::IDX_PWR_EN, 2'b00};
    localparam logic [11:0] A_PC = {csim_pkg::IDX_PWR_CTL, 2'b00};
    logic hclk, hresetn, hsel, hwrite, hready, stall, pin_n, flag, lv_v;
    logic resp;
    logic [11:0] haddr;
    logic [1:0] htrans, dac_in_valid, dac_tick, lv_l, lv_r;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic [15:0] d;
    csim_pkg::csim_stereo_t [1:0] dac_in_data, dac_out;
    int checks, n_fail, i, n;

    csim_host u_csim_host (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .stall(stall));
    csim_regs u_csim_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(resp),
        .hrdata(hrdata), .powerdown_pin_n(pin_n), .dac_in_data(dac_in_data),
        .dac_in_valid(dac_in_valid), .dac_in_ready(), .dac_tick(dac_tick),
        .dac_out(dac_out), .adc_left_level(lv_l), .adc_right_level(lv_r),
        .adc_level_valid(lv_v), .left_adc_source(), .right_adc_source(),
        .left_mic_boost(), .right_mic_boost(), .left_adc_gain(),
        .right_adc_gain(), .left_dac2_mix_mute(), .right_dac2_mix_mute(),
        .left_dac2_mix_gain(), .right_dac2_mix_gain(), .channel_enables(),
        .converter_powerdown_flag(flag));

    task automatic rd(input logic [11:0] a, input logic [15:0] e);
        logic [15:0] q;
        u_csim_host.xfer(1'b0, a, 16'h0000, q);
        `CHK("reg", e, q)
        `CHK("resp", 1'b0, resp)
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] v);
        logic [15:0] q;
        u_csim_host.xfer(1'b1, a, v, q);
    endtask
    task automatic lvl(input logic [1:0] l, input logic [1:0] r);
        @(posedge hclk);
        lv_l <= l;
        lv_r <= r;
        lv_v <= 1'b1;
        @(posedge hclk);
        lv_v <= 1'b0;
    endtask
    // One sample each, then a second tick that finds the buffer empty
    task automatic under();
        @(posedge hclk);
        dac_in_valid <= 2'b11;
        @(posedge hclk);
        dac_in_valid <= 2'b00;
        dac_tick <= 2'b11;
        @(posedge hclk);
        #1 `CHK("dac", dac_in_data, dac_out)
        @(posedge hclk);
        dac_tick <= 2'b00;
        #1 `CHK("dac", 64'h0, dac_out)
    endtask
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        complete_run();
    end
    always @(posedge stall) begin
        n_fail++;
        complete_run();
    end
    initial begin
        hresetn = 1'b0;
        pin_n = 1'b1;
        dac_in_valid = 2'b00;
        dac_tick = 2'b00;
        lv_l = 2'h0;
        lv_r = 2'h0;
        lv_v = 1'b0;
        dac_in_data = {32'h5a5a0202, 32'ha5a50101};
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(A_ADC, csim_pkg::ADC_RESET);
        rd(A_MIX, csim_pkg::MIX_RESET);
        rd(A_ST, csim_pkg::STATUS_RESET);
        rd(A_PC, 16'h8001);
        rd(12'h040, 16'h0000);
        wr(A_ADC, 16'h1234);
        rd(A_ADC, 16'h0000);
        wr(A_PC, 16'h0000);
        for (n = 0; n < 40 && flag !== 1'b0; n++)
            @(posedge hclk);
        `CHK("flag", 1'b0, flag)
        wr(A_MIX, 16'h1f00);
        rd(A_MIX, csim_pkg::MIX_RESET);
        for (i = 0; i < 3; i++) begin
            wr(A_EN, 16'h003f ^ (16'h0001 << (i == 0 ? 1 : i + 3)));
            wr(A_MIX, 16'h1f00);
            rd(A_MIX, csim_pkg::MIX_RESET);
        end
        wr(A_EN, 16'h003f);
        wr(A_MIX, 16'h9f00);
        rd(A_MIX, 16'h9f00);
        wr(A_MIX, 16'h0880);
        rd(A_MIX, 16'h0880);
        for (i = 0; i < 8; i++) begin
            d = {i[2:0], i[0], 4'(2 * i + 1),
                 3'(7 - i), !i[0], 4'(14 - 2 * i)};
            wr(A_ADC, d);
            rd(A_ADC, d);
        end
        lvl(2'h2, 2'h1);
        lvl(2'h1, 2'h0);
        rd(A_ST, 16'h0006);
        rd(A_ST, 16'h0000);
        under();
        rd(A_ST, 16'h0300);
        under();
        lvl(2'h3, 2'h3);
        wr(A_ST, 16'h0000);
        rd(A_ST, 16'h0000);
        under();
        lvl(2'h3, 2'h3);
        wr(A_EN, 16'h003a);
        rd(A_ST, 16'h020c);
        wr(A_EN, 16'h003f);
        lvl(2'h3, 2'h0);
        pin_n <= 1'b0;
        repeat (4) @(posedge hclk);
        rd(A_ST, 16'h0000);
        rd(A_ADC, 16'h0000);
        rd(A_MIX, csim_pkg::MIX_RESET);
        complete_run();
    end
endmodule
